// ==== hdl/tlip_cfg.svh ====
// constants for the two-level interrupt priority controller
// assumes inclusion by tlip_pkg and tlip_ctrl only
`ifndef TLIP_CFG_SVH
`define TLIP_CFG_SVH
`define TLIP_OFF_SYSCTL 12'h000
`define TLIP_OFF_LVL_FIRST 12'h004
`define TLIP_OFF_LVL_SECOND 12'h008
`define TLIP_OFF_LVL_THIRD 12'h00c
`define TLIP_OFF_ENABLE 12'h010
`define TLIP_OFF_PENDING 12'h014
`define TLIP_OFF_STATUS 12'h018
`define TLIP_BIT_MODE_LO 4
`define TLIP_BIT_MODE_HI 5
`define TLIP_SYSCTL_RST 8'h00
`define TLIP_LVL_RST 24'h000000
`define TLIP_ENABLE_RST 32'h00000000
`define TLIP_NMI_VEC 8'h07
`define TLIP_SRC_VEC_BASE 8'h10
`define TLIP_VEC_SHIFT 2
`define TLIP_VEC_LIMIT 256
`define TLIP_ST_VEC_LO 2
`define TLIP_ST_REQ 10
`define TLIP_ST_NMI 11
`define TLIP_ST_STATE 12
`define TLIP_LVL_BITS 24
`define TLIP_MAX_SRC 32
`endif

// ==== hdl/tlip_pkg.sv ====
// types for the two-level interrupt priority controller
// assumes tlip_cfg.svh for sizes
`include "tlip_cfg.svh"
package tlip_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tlip_apb_req_s;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tlip_apb_rsp_s;
   typedef enum logic [1:0] {
      TLIP_IDLE = 2'b00,
      TLIP_WAIT = 2'b01,
      TLIP_STACK = 2'b10,
      TLIP_MASK = 2'b11
   } tlip_state_e;
   typedef struct packed {
      logic [7:0] sysctl;
      logic [`TLIP_LVL_BITS-1:0] level;
      logic [`TLIP_MAX_SRC-1:0] enable;
      logic [31:0] prdata;
      logic pslverr;
      logic req;
      logic nmi;
      logic [7:0] vec;
      logic [15:0] vec_addr;
      logic stack_req;
      logic set_i;
      logic set_ui;
      logic mode1_taken;
      tlip_state_e state;
   } tlip_regs_s;
endpackage

// ==== hdl/tlip_ctrl.sv ====
// interrupt acceptance, masking and priority controller with apb registers
// assumes a cpu core that acks requests at instruction boundaries,
// does the stacking on request and reports its condition-code mask flags
`timescale 1ns/1ps
`default_nettype none
`include "tlip_cfg.svh"
// Function
// R1 - nmi accepted except reset or standby
// R2 - per-source enable gates every request
// R3 - mode bits select mode 0 or 1
// R4 - mode 0: global mask blocks maskables
// R5 - level 1 requests win over level 0
// R6 - same level: fixed order picks winner
// R7 - losing requests stay pending, not dropped
// R8 - selected source gets priority and vector
// R9 - mode 1: level 0 needs global clear
// R10 - mode 1: level 1 needs either clear
// R11 - global clear: user flag ignored
// R12 - level select bits group sources
// R13 - handling starts after current instruction ends
// R14 - entry stacks program counter and flags
// R15 - mode 0: set global mask after stack
// R16 - mode 1: set both masks after stack
// R17 - vector address formed for accepted source
// R18 - request and vector held until ack
module tlip_ctrl #(
   parameter int NUM_SRC = 32
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire tlip_pkg::tlip_apb_req_s apb_i,
   output tlip_pkg::tlip_apb_rsp_s apb_o,
   input wire logic nmi_i,
   input wire logic standby_i,
   input wire logic [NUM_SRC-1:0] src_req_i,
   input wire logic cpu_global_mask_i,
   input wire logic user_mask_flag_i,
   input wire logic cpu_ack_i,
   input wire logic stack_done_i,
   output logic irq_req_o,
   output logic irq_nmi_o,
   output logic [7:0] irq_vec_o,
   output logic stack_req_o,
   output logic set_global_mask_o,
   output logic set_user_mask_o,
   output logic [15:0] vec_addr_o
);
   import tlip_pkg::*;

   initial begin
      if (NUM_SRC < 1 || NUM_SRC > `TLIP_MAX_SRC) begin
         $error("tlip_ctrl: NUM_SRC out of range");
      end
      // every source needs a level bit in the three level registers
      if (lvl_index(NUM_SRC - 1) >= `TLIP_LVL_BITS) begin
         $error("tlip_ctrl: too few level bits for NUM_SRC");
      end
      // vector numbers of all sources must fit the 8-bit vector port
      if (int'(`TLIP_SRC_VEC_BASE) + NUM_SRC > `TLIP_VEC_LIMIT) begin
         $error("tlip_ctrl: source vectors overflow 8 bits");
      end
   end

   tlip_regs_s q;
   tlip_regs_s next_q;

   // two external requests share one level bit above the first pair
   function automatic int lvl_index(input int src);
      int g;
      g = (src < 2) ? src : (src / 2) + 1;
      return ((g / 8) * 8) + (7 - (g % 8));
   endfunction

   function automatic logic [7:0] src_vec(input int src);
      return `TLIP_SRC_VEC_BASE + 8'(src);
   endfunction

   // one decode serves the read mux and the write strobes
   localparam logic [2:0] SEL_SYSCTL = 3'h0;
   localparam logic [2:0] SEL_FIRST = 3'h1;
   localparam logic [2:0] SEL_SECOND = 3'h2;
   localparam logic [2:0] SEL_THIRD = 3'h3;
   localparam logic [2:0] SEL_ENABLE = 3'h4;
   localparam logic [2:0] SEL_PENDING = 3'h5;
   localparam logic [2:0] SEL_STATUS = 3'h6;
   localparam logic [2:0] SEL_NONE = 3'h7;

   function automatic logic [2:0] reg_sel(input logic [11:0] addr);
      logic [2:0] s;
      if (addr == `TLIP_OFF_SYSCTL) begin
         s = SEL_SYSCTL;
      end else if (addr == `TLIP_OFF_LVL_FIRST) begin
         s = SEL_FIRST;
      end else if (addr == `TLIP_OFF_LVL_SECOND) begin
         s = SEL_SECOND;
      end else if (addr == `TLIP_OFF_LVL_THIRD) begin
         s = SEL_THIRD;
      end else if (addr == `TLIP_OFF_ENABLE) begin
         s = SEL_ENABLE;
      end else if (addr == `TLIP_OFF_PENDING) begin
         s = SEL_PENDING;
      end else if (addr == `TLIP_OFF_STATUS) begin
         s = SEL_STATUS;
      end else begin
         s = SEL_NONE;
      end
      return s;
   endfunction

   // lowest index wins among the eligible sources of one level
   function automatic logic [8:0] pick_src(input logic [NUM_SRC-1:0] elig);
      logic [8:0] r;
      r = 9'h000;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            r = {1'b1, src_vec(i)};
         end
      end
      return r;
   endfunction

   // combinational decode results
   logic mode1;
   logic lvl0_ok;
   logic lvl1_ok;
   logic [NUM_SRC-1:0] pending;
   logic [NUM_SRC-1:0] on_lvl1;
   logic sel_found;
   logic [7:0] sel_vec;
   logic nmi_ok;
   logic acc_setup;
   logic acc_write;
   logic [31:0] rd_val;
   logic rd_err;
   logic [31:0] pend_word;
   logic [2:0] sel;
   logic [8:0] pick_hi;
   logic [8:0] pick_lo;
   logic [31:0] status_word;

   always_comb begin
      mode1 = q.sysctl[`TLIP_BIT_MODE_LO]; // R3
      nmi_ok = nmi_i & ~standby_i & ~rst_i; // R1
      // R4 R9
      lvl0_ok = ~cpu_global_mask_i;
      // R10 R11
      if (mode1) begin
         lvl1_ok = ~cpu_global_mask_i | ~user_mask_flag_i;
      end else begin
         // mode 0: level 1 obeys the global mask only
         lvl1_ok = ~cpu_global_mask_i;
      end
      pending = src_req_i & q.enable[NUM_SRC-1:0]; // R2
      for (int i = 0; i < NUM_SRC; i++) begin
         on_lvl1[i] = q.level[lvl_index(i)]; // R12
      end
      // R5 R6: level 1 scan first, lowest index ranks highest
      pick_hi = pick_src(pending & on_lvl1 & {NUM_SRC{lvl1_ok}});
      pick_lo = pick_src(pending & ~on_lvl1 & {NUM_SRC{lvl0_ok}});
      if (pick_hi[8]) begin
         sel_found = 1'b1;
         sel_vec = pick_hi[7:0];
      end else begin
         sel_found = pick_lo[8];
         sel_vec = pick_lo[7:0];
      end
   end

   // register read mux, decoded once per cycle
   always_comb begin
      pend_word = 32'h00000000;
      pend_word[NUM_SRC-1:0] = pending;
      // status: vector, request, nmi and state in fixed fields
      status_word = 32'h00000000;
      status_word[`TLIP_ST_VEC_LO +: 8] = q.vec;
      status_word[`TLIP_ST_REQ] = q.req;
      status_word[`TLIP_ST_NMI] = q.nmi;
      status_word[`TLIP_ST_STATE +: 2] = q.state;
      sel = reg_sel(apb_i.paddr);
      acc_setup = apb_i.psel & ~apb_i.penable;
      acc_write = apb_i.psel & apb_i.penable & apb_i.pwrite;
      rd_err = 1'b0;
      rd_val = 32'h00000000;
      if (sel == SEL_SYSCTL) begin
         rd_val = {24'h000000, q.sysctl};
      end else if (sel == SEL_FIRST) begin
         rd_val = {24'h000000, q.level[7:0]};
      end else if (sel == SEL_SECOND) begin
         rd_val = {24'h000000, q.level[15:8]};
      end else if (sel == SEL_THIRD) begin
         rd_val = {24'h000000, q.level[23:16]};
      end else if (sel == SEL_ENABLE) begin
         rd_val = q.enable;
      end else if (sel == SEL_PENDING) begin
         rd_val = pend_word;
      end else if (sel == SEL_STATUS) begin
         rd_val = status_word;
      end else begin
         rd_err = 1'b1;
      end
   end

   always_comb begin
      next_q = q;
      next_q.set_i = 1'b0;
      next_q.set_ui = 1'b0;
      if (acc_setup) begin
         // read data taken in setup, so it stands through access
         next_q.prdata = apb_i.pwrite ? 32'h00000000 : rd_val;
         next_q.pslverr = rd_err;
      end
      if (acc_write) begin
         if (sel == SEL_SYSCTL) begin
            next_q.sysctl = apb_i.pwdata[7:0];
         end else if (sel == SEL_FIRST) begin
            next_q.level[7:0] = apb_i.pwdata[7:0];
         end else if (sel == SEL_SECOND) begin
            next_q.level[15:8] = apb_i.pwdata[7:0];
         end else if (sel == SEL_THIRD) begin
            next_q.level[23:16] = apb_i.pwdata[7:0];
         end else if (sel == SEL_ENABLE) begin
            next_q.enable = apb_i.pwdata;
         end
      end
      case (q.state)
         TLIP_IDLE: begin
            // R8: nmi outranks every maskable source
            if (nmi_ok) begin
               next_q.req = 1'b1;
               next_q.nmi = 1'b1;
               next_q.vec = `TLIP_NMI_VEC;
               next_q.state = TLIP_WAIT;
            end else if (sel_found) begin
               next_q.req = 1'b1;
               next_q.nmi = 1'b0;
               next_q.vec = sel_vec; // R8
               next_q.state = TLIP_WAIT;
            end
         end
         TLIP_WAIT: begin
            // R18 R13: frozen until the core acks at a boundary
            if (cpu_ack_i) begin
               next_q.req = 1'b0;
               next_q.stack_req = 1'b1; // R14
               next_q.mode1_taken = mode1;
               next_q.vec_addr = 16'(q.vec) << `TLIP_VEC_SHIFT; // R17
               next_q.state = TLIP_STACK;
            end
         end
         TLIP_STACK: begin
            if (stack_done_i) begin
               next_q.stack_req = 1'b0;
               next_q.set_i = 1'b1; // R15
               next_q.set_ui = q.mode1_taken; // R16
               next_q.state = TLIP_MASK;
            end
         end
         TLIP_MASK: begin
            // R7: sources left out are still pending, rescanned in TLIP_IDLE next
            next_q.state = TLIP_IDLE;
         end
         default: begin
            next_q.state = TLIP_IDLE;
         end
      endcase
   end

   // one register stage holds all state
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         q.sysctl <= `TLIP_SYSCTL_RST;
         q.level <= `TLIP_LVL_RST;
         q.enable <= `TLIP_ENABLE_RST;
         q.prdata <= 32'h00000000;
         q.pslverr <= 1'b0;
         q.req <= 1'b0;
         q.nmi <= 1'b0;
         q.vec <= 8'h00;
         q.vec_addr <= 16'h0000;
         q.stack_req <= 1'b0;
         q.set_i <= 1'b0;
         q.set_ui <= 1'b0;
         q.mode1_taken <= 1'b0;
         q.state <= TLIP_IDLE;
      end else begin
         q <= next_q;
      end
   end

   always_comb begin
      apb_o.prdata = q.prdata;
      // error flag shown only in the access phase
      apb_o.pslverr = q.pslverr & apb_i.psel & apb_i.penable;
      // no wait states: pready is tied high
      apb_o.pready = 1'b1;
      irq_req_o = q.req;
      irq_nmi_o = q.nmi;
      irq_vec_o = q.vec;
      stack_req_o = q.stack_req;
      set_global_mask_o = q.set_i;
      set_user_mask_o = q.set_ui;
      vec_addr_o = q.vec_addr;
   end
endmodule
`default_nettype wire

// ==== dv/tlip_props.sv ====
// port assertions for the interrupt controller
// assumes it is bound into every tlip_ctrl
`timescale 1ns/1ps
`default_nettype none
module tlip_props #(
   parameter int NUM_SRC = 32
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic nmi_i,
   input wire logic standby_i,
   input wire logic cpu_global_mask_i,
   input wire logic user_mask_flag_i,
   input wire logic cpu_ack_i,
   input wire logic stack_done_i,
   input wire logic irq_req_o,
   input wire logic irq_nmi_o,
   input wire logic [7:0] irq_vec_o,
   input wire logic stack_req_o,
   input wire logic set_global_mask_o,
   input wire logic [15:0] vec_addr_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_ack; irq_req_o && cpu_ack_i; endsequence
   sequence s_stk; stack_req_o && stack_done_i; endsequence
   a_req_hold: assert property (irq_req_o && !cpu_ack_i |=>
      irq_req_o && $stable(irq_vec_o)) else $error("req hold");
   a_ack_stack: assert property (s_ack |=>
      !irq_req_o && stack_req_o) else $error("no stack");
   a_vec_addr: assert property (s_ack |=>
      vec_addr_o == {6'h0, $past(irq_vec_o), 2'b00}) else $error("vaddr");
   a_mask_set: assert property (s_stk |=>
      set_global_mask_o && !stack_req_o ##1 !set_global_mask_o)
      else $error("mask pulse");
   a_nmi_take: assert property ((nmi_i && !standby_i && !irq_req_o &&
      !stack_req_o && !set_global_mask_o)[*2] |=> irq_req_o && irq_nmi_o)
      else $error("nmi lost");
   a_no_standby: assert property ($rose(irq_req_o) && irq_nmi_o |->
      !$past(standby_i)) else $error("nmi in standby");
   a_mask_gate: assert property ($rose(irq_req_o) && !irq_nmi_o |->
      !($past(cpu_global_mask_i) && $past(user_mask_flag_i)))
      else $error("masked taken");
   a_nmi_vec: assert property (irq_req_o && irq_nmi_o |->
      irq_vec_o == 8'h07) else $error("nmi vector");
endmodule
bind tlip_ctrl tlip_props #(.NUM_SRC(NUM_SRC)) u_props (.*);
`default_nettype wire

// ==== dv/tlip_cpu_model.sv ====
// cpu core stand-in: acks, stacks and owns the mask flags
// assumes the request handshake of tlip_ctrl
`timescale 1ns/1ps
`default_nettype none
module tlip_cpu_model (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic stk_i,
   input wire logic set_g_i,
   input wire logic set_u_i,
   input wire logic ld_i,
   input wire logic [1:0] fl_i,
   input wire logic [1:0] wt_i,
   output logic ack_o,
   output logic done_o,
   output logic g_o,
   output logic u_o
);
   int cnt;
   always @(posedge ref_clk_i) begin
      ack_o <= 0;
      done_o <= 0;
      cnt <= (req_i || stk_i) ? cnt + 1 : 0;
      if (rst_i) begin
         {g_o, u_o} <= 2'b11;
      end else begin
         if (ld_i) {g_o, u_o} <= fl_i;
         if (set_g_i) g_o <= 1;
         if (set_u_i) u_o <= 1;
         // instruction end after wt_i cycles
         if (req_i && !ack_o && cnt >= wt_i) ack_o <= 1;
         if (stk_i && !done_o && cnt >= wt_i) done_o <= 1;
      end
   end
endmodule
`default_nettype wire

// ==== dv/tb_two_level_interrupt_priority_control.sv ====
// self-checking bench for tlip_ctrl with a cpu stand-in
// assumes tlip_pkg, tlip_ctrl, tlip_cpu_model and tlip_props
`timescale 1ns/1ps
`default_nettype none
module tb_two_level_interrupt_priority_control;
   import tlip_pkg::*;
   logic clk, rst, nmi, sb, ack, done, g, u, ld, irq, inmi, stk, sg, su;
   logic [31:0] src;
   logic [1:0] fl, wt;
   logic [7:0] vec;
   logic [15:0] va;
   tlip_apb_req_s req;
   tlip_apb_rsp_s rsp;
   int n_fail, total_checks;
   tlip_ctrl u_dut (.ref_clk_i(clk), .rst_i(rst), .apb_i(req), .apb_o(rsp),
      .nmi_i(nmi), .standby_i(sb), .src_req_i(src), .cpu_global_mask_i(g),
      .user_mask_flag_i(u), .cpu_ack_i(ack), .stack_done_i(done),
      .irq_req_o(irq), .irq_nmi_o(inmi), .irq_vec_o(vec), .stack_req_o(stk),
      .set_global_mask_o(sg), .set_user_mask_o(su), .vec_addr_o(va));
   tlip_cpu_model u_cpu (.ref_clk_i(clk), .rst_i(rst), .req_i(irq),
      .stk_i(stk), .set_g_i(sg), .set_u_i(su), .ld_i(ld), .fl_i(fl),
      .wt_i(wt), .ack_o(ack), .done_o(done), .g_o(g), .u_o(u));
   task automatic chk(input logic [31:0] s, e, input string nm);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic apb(input bit w, input int a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge clk) req <= '{1'b1, 1'b0, w, 12'(a), d};
      @(posedge clk) req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      r = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
   endtask
   function automatic int lb(int i);
      int gr = i < 2 ? i : i / 2 + 1;
      return gr / 8 * 8 + 7 - gr % 8;
   endfunction
   function automatic int ev(bit [31:0] q, bit [23:0] lv, bit m, gi, ui,
      nm, s);
      if (nm && !s) return 7;
      for (int l = 1; l >= 0; l--)
         for (int i = 0; i < 32; i++)
            if (q[i] && lv[lb(i)] == l && (!gi || (l == 1 && m && !ui)))
               return 16 + i;
      return -1;
   endfunction
   task automatic trial(bit m, mh, bit [23:0] lv, bit [31:0] en, q,
      bit gi, ui, nm, s);
      logic [31:0] r;
      logic e;
      int x;
      x = ev(q & en, lv, m, gi, ui, nm, s);
      apb(1, 0, {26'h0, mh, m, 4'h0}, r, e);
      apb(1, 16, en, r, e);
      for (int k = 0; k < 3; k++) apb(1, 4 + 4 * k, {24'h0, lv[8 * k +: 8]}, r, e);
      @(posedge clk) begin
         ld <= 1;
         fl <= {gi, ui};
         wt <= 2'($urandom);
      end
      @(posedge clk) begin
         ld <= 0;
         src <= q;
         nmi <= nm;
         sb <= s;
      end
      for (int k = 0; k < 20 && irq !== 1'b1; k++) @(negedge clk);
      chk(irq === 1'b1 ? {24'h0, vec} : '1, 32'(x), "vector");
      chk(irq === 1'b1 ? inmi : 1'b0, x == 7, "nmi flag");
      if (x < 0) begin
         apb(0, 20, 0, r, e);
         chk(r, q & en, "pending");
      end
      @(posedge clk) {src, nmi, sb} <= '0;
      if (x >= 0) begin
         for (int k = 0; k < 40 && sg !== 1'b1; k++) @(negedge clk);
         chk({16'h0, va}, 32'(x * 4), "vaddr");
         chk(su, m, "umask set");
         @(negedge clk);
         chk({g, u}, {1'b1, m | ui}, "flags");
         apb(0, 24, 0, r, e);
         chk(r, {20'h0, x == 7, 1'b0, 8'(x), 2'b00}, "status");
      end
      repeat (4) @(posedge clk);
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      logic [31:0] r, rv;
      logic e;
      {nmi, sb, src, ld, fl, wt} = '0;
      req = '0;
      rst = 1;
      void'($urandom(41));
      repeat (6) @(posedge clk);
      rst <= 0;
      for (int k = 0; k < 8; k++) begin
         apb(0, 4 * k, 0, r, e);
         chk(r, 0, "reset value");
         chk(e, k == 7, "slverr");
      end
      trial(1, 0, 24'h20, '1, 32'hd, 1, 0, 0, 0);
      for (int t = 0; t < 80; t++) begin
         rv = $urandom;
         trial(rv[0], rv[1], 24'($urandom), $urandom | $urandom,
            $urandom & $urandom, rv[2], rv[3], rv[4] & rv[5], rv[6] & rv[7]);
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire
